// ===== design/rci_reset_init.sv
`timescale 1ns/10ps
// Overview of operation
// - untouched registers keep contents except power-on
// - defined registers load by reset category
// - watchdog wake leaves most registers unchanged
// - power-on: pc zero, instruction/timeout/powerdown flags set, power-on/brown-out flags cleared, faults cleared
// - brown-out/instruction flag updates as tabled
// - master-clear in low power sets timeout
// - master-clear full power keeps cause flags, clears stack flags
// - watchdog run timeout clears timeout flag
// - idle wake continues at pc plus two
// - stack faults set flags, reset if enabled
// - vectored interrupt wake loads interrupt vector
// - software brown-out enable reset value rules
// - power reset loads interrupt control two/three
// - other resets clear stack, latches, pointers
// - non-vectored wake keeps registers, pc advances by two
// - vectored wake pushes pc, bumps stack pointer
// - brown-out enable reads zero in status unless software
module rci_reset_init (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire rci_pkg::rci_event_type event_code,
   input wire logic event_valid,
   input wire logic [1:0] brownout_config_field,
   input wire logic stack_fault_reset_enable,
   input wire logic [20:0] pc_current,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [20:0] pc_out,
   output logic core_reset,
   output logic sw_brownout_enable,
   output logic irq
);
   import rci_pkg::*;

   typedef struct packed {
      rci_state_type st;
      rci_event_type cause;
      rci_cat_type cat;
      logic sw_brownout_enable;
      logic instr_reset_flag_n;
      logic timeout_flag_n;
      logic powerdown_flag_n;
      logic poweron_flag_n;
      logic brownout_flag_n;
      logic stack_full_flag;
      logic stack_underflow_flag;
      logic [4:0] stack_ptr;
      logic [20:0] tos;
      logic [20:0] pc;
      logic [7:0] interrupt_control_primary;
      logic [7:0] interrupt_control_two;
      logic [7:0] interrupt_control_three;
      logic [12:0] pc_latch;
      logic [21:0] table_ptr;
      logic [RCI_NUM_EVENTS-1:0] int_stat;
      logic [RCI_NUM_EVENTS-1:0] int_mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic core_reset;
      logic irq;
      logic sw_bor_gated;
   } rci_state_reg_type;

   rci_state_reg_type s_r;
   rci_state_reg_type s_nxt;

   logic [7:0] status_view;
   logic [7:0] stack_view;
   logic apb_setup;
   logic apb_rd;
   logic apb_wr;
   logic sw_bor_mode;
   logic [RCI_NUM_EVENTS-1:0] ev_hit;

   always_comb begin
      sw_bor_mode = (brownout_config_field == RCI_BOR_SW_CONFIG);
      status_view = 8'h00;
      status_view[RCI_STAT_SWBOR_BIT] = s_r.sw_brownout_enable & sw_bor_mode;
      status_view[RCI_STAT_IRST_BIT] = s_r.instr_reset_flag_n;
      status_view[RCI_STAT_TMO_BIT] = s_r.timeout_flag_n;
      status_view[RCI_STAT_PDN_BIT] = s_r.powerdown_flag_n;
      status_view[RCI_STAT_POR_BIT] = s_r.poweron_flag_n;
      status_view[RCI_STAT_BOR_BIT] = s_r.brownout_flag_n;
      stack_view = {s_r.stack_full_flag, s_r.stack_underflow_flag, 1'b0, s_r.stack_ptr};
      apb_setup = psel & ~penable;
      apb_rd = psel & penable & ~pwrite & s_r.pready;
      apb_wr = psel & penable & pwrite & s_r.pready;
   end

   // one sticky bit per cause
   genvar g;
   generate
      for (g = 0; g < RCI_NUM_EVENTS; g++) begin : g_ev
         assign ev_hit[g] = event_valid && (event_code == rci_event_type'(g)) && (g != 0);
      end
   endgenerate

   always_comb begin
      s_nxt = s_r;
      s_nxt.core_reset = 1'b0;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      // apb: no wait state, answer in access cycle after setup
      if (apb_setup) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = 32'h00000000;
         case (paddr)
            RCI_ADDR_STATUS: s_nxt.prdata = {24'h000000, status_view};
            RCI_ADDR_STACK: s_nxt.prdata = {24'h000000, stack_view};
            RCI_ADDR_PC: s_nxt.prdata = {11'h000, s_r.pc};
            RCI_ADDR_TOS: s_nxt.prdata = {11'h000, s_r.tos};
            RCI_ADDR_INTCTL: s_nxt.prdata = {8'h00, s_r.interrupt_control_three,
               s_r.interrupt_control_two, s_r.interrupt_control_primary};
            RCI_ADDR_PCLAT: s_nxt.prdata = {19'h00000, s_r.pc_latch};
            RCI_ADDR_TBLPTR: s_nxt.prdata = {10'h000, s_r.table_ptr};
            RCI_ADDR_CAUSE: s_nxt.prdata = {26'h0000000, s_r.cat, s_r.cause};
            RCI_ADDR_INT_STAT: s_nxt.prdata = {20'h00000, s_r.int_stat};
            RCI_ADDR_INT_MASK: s_nxt.prdata = {20'h00000, s_r.int_mask};
            RCI_ADDR_CTRL: s_nxt.prdata = {31'h00000000, s_r.sw_brownout_enable};
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      if (apb_wr) begin
         case (paddr)
            RCI_ADDR_STATUS: begin
               s_nxt.sw_brownout_enable = pwdata[RCI_STAT_SWBOR_BIT];
               s_nxt.instr_reset_flag_n = pwdata[RCI_STAT_IRST_BIT];
               s_nxt.poweron_flag_n = pwdata[RCI_STAT_POR_BIT];
               s_nxt.brownout_flag_n = pwdata[RCI_STAT_BOR_BIT];
            end
            RCI_ADDR_STACK: begin
               s_nxt.stack_full_flag = pwdata[7];
               s_nxt.stack_underflow_flag = pwdata[6];
            end
            RCI_ADDR_INTCTL: begin
               s_nxt.interrupt_control_primary = pwdata[7:0];
               s_nxt.interrupt_control_two = pwdata[15:8];
               s_nxt.interrupt_control_three = pwdata[23:16];
            end
            RCI_ADDR_INT_MASK: s_nxt.int_mask = pwdata[RCI_NUM_EVENTS-1:0];
            RCI_ADDR_CTRL: s_nxt.sw_brownout_enable = pwdata[0];
            default: ;
         endcase
      end
      // read of status clears; new event wins below
      if (apb_rd && paddr == RCI_ADDR_INT_STAT) begin
         s_nxt.int_stat = '0;
      end
      s_nxt.int_stat = s_nxt.int_stat | ev_hit;

      case (s_r.st)
         RCI_ST_IDLE: begin
            if (event_valid && event_code != RCI_EV_NONE) begin
               s_nxt.cause = event_code;
               s_nxt.st = RCI_ST_DECODE;
            end
         end
         RCI_ST_DECODE: begin
            // category from latched cause, and reset enable for stack faults
            case (s_r.cause)
               RCI_EV_POR, RCI_EV_BOR: s_nxt.cat = RCI_CAT_POWER;
               RCI_EV_WDT_IDLE, RCI_EV_INT_WAKE: s_nxt.cat = RCI_CAT_WAKE;
               RCI_EV_STK_UNF: s_nxt.cat = stack_fault_reset_enable ? RCI_CAT_RESET : RCI_CAT_NONE;
               RCI_EV_STK_FULL: s_nxt.cat = stack_fault_reset_enable ? RCI_CAT_RESET : RCI_CAT_NONE;
               default: s_nxt.cat = RCI_CAT_RESET;
            endcase
            s_nxt.st = RCI_ST_APPLY;
         end
         RCI_ST_APPLY: begin
            s_nxt.st = RCI_ST_IDLE;
            // status flags per cause
            case (s_r.cause)
               RCI_EV_POR: begin
                  s_nxt.instr_reset_flag_n = 1'b1;
                  s_nxt.timeout_flag_n = 1'b1;
                  s_nxt.powerdown_flag_n = 1'b1;
                  s_nxt.poweron_flag_n = 1'b0;
                  s_nxt.brownout_flag_n = 1'b0;
                  s_nxt.stack_full_flag = 1'b0;
                  s_nxt.stack_underflow_flag = 1'b0;
               end
               RCI_EV_BOR: begin
                  s_nxt.instr_reset_flag_n = 1'b1;
                  s_nxt.timeout_flag_n = 1'b1;
                  s_nxt.powerdown_flag_n = 1'b1;
                  s_nxt.brownout_flag_n = 1'b0;
               end
               RCI_EV_RESET_INSTR: s_nxt.instr_reset_flag_n = 1'b0;
               RCI_EV_PINRST_RUN: s_nxt.timeout_flag_n = 1'b1;
               RCI_EV_PINRST_IDLE: begin
                  s_nxt.timeout_flag_n = 1'b1;
                  s_nxt.powerdown_flag_n = 1'b0;
               end
               RCI_EV_PINRST_FULL: ;
               RCI_EV_WDT_RUN: s_nxt.timeout_flag_n = 1'b0;
               RCI_EV_WDT_IDLE: begin
                  s_nxt.timeout_flag_n = 1'b0;
                  s_nxt.powerdown_flag_n = 1'b0;
               end
               RCI_EV_INT_WAKE: s_nxt.powerdown_flag_n = 1'b0;
               RCI_EV_STK_FULL: s_nxt.stack_full_flag = 1'b1;
               RCI_EV_STK_UNF: s_nxt.stack_underflow_flag = 1'b1;
               default: ;
            endcase
            // software brown-out enable
            if (s_r.cause == RCI_EV_POR) begin
               s_nxt.sw_brownout_enable = 1'b1;
            end else if (s_r.cat != RCI_CAT_NONE && !(sw_bor_mode && s_r.sw_brownout_enable)) begin
               s_nxt.sw_brownout_enable = 1'b0;
            end
            // defined-reset registers; others untouched, pseudo-registers absent
            case (s_r.cat)
               RCI_CAT_POWER: begin
                  s_nxt.pc = RCI_RESET_VECTOR;
                  s_nxt.core_reset = 1'b1;
                  s_nxt.tos = '0;
                  s_nxt.stack_ptr = '0;
                  s_nxt.interrupt_control_primary = {7'h00, s_r.interrupt_control_primary[0]};
                  s_nxt.interrupt_control_two = RCI_INTCTL2_INIT;
                  s_nxt.interrupt_control_three = RCI_INTCTL3_INIT;
                  s_nxt.pc_latch = '0;
                  s_nxt.table_ptr = '0;
               end
               RCI_CAT_RESET: begin
                  s_nxt.pc = RCI_RESET_VECTOR;
                  s_nxt.core_reset = 1'b1;
                  s_nxt.tos = '0;
                  s_nxt.stack_ptr = '0;
                  if (s_r.cause != RCI_EV_STK_FULL && s_r.cause != RCI_EV_STK_UNF) begin
                     s_nxt.stack_full_flag = 1'b0;
                     s_nxt.stack_underflow_flag = 1'b0;
                  end
                  s_nxt.interrupt_control_primary = {7'h00, s_r.interrupt_control_primary[0]};
                  s_nxt.interrupt_control_two = RCI_INTCTL2_INIT;
                  s_nxt.interrupt_control_three = RCI_INTCTL3_INIT;
                  s_nxt.pc_latch = '0;
                  s_nxt.table_ptr = '0;
               end
               RCI_CAT_WAKE: begin
                  s_nxt.pc = pc_current + RCI_PC_STEP;
                  if (s_r.cause == RCI_EV_INT_WAKE &&
                        (s_r.interrupt_control_primary[7] || s_r.interrupt_control_primary[6])) begin
                     s_nxt.pc = s_r.interrupt_control_primary[7] ? RCI_HIGH_VECTOR : RCI_LOW_VECTOR;
                     s_nxt.tos = pc_current;
                     if (s_r.stack_ptr != RCI_STACK_PTR_MAX) begin
                        s_nxt.stack_ptr = s_r.stack_ptr + 5'h01;
                     end
                  end
               end
               default: ;
            endcase
         end
         default: s_nxt.st = RCI_ST_IDLE;
      endcase
      // output copy of the enable, gated by the configuration
      s_nxt.sw_bor_gated = s_nxt.sw_brownout_enable & sw_bor_mode;
      s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.st <= RCI_ST_IDLE;
         s_r.cause <= RCI_EV_NONE;
         s_r.cat <= RCI_CAT_NONE;
         s_r.instr_reset_flag_n <= 1'b1;
         s_r.timeout_flag_n <= 1'b1;
         s_r.powerdown_flag_n <= 1'b1;
         s_r.interrupt_control_two <= RCI_INTCTL2_INIT;
         s_r.interrupt_control_three <= RCI_INTCTL3_INIT;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      prdata = s_r.prdata;
      pready = s_r.pready;
      pslverr = s_r.pslverr;
      pc_out = s_r.pc;
      core_reset = s_r.core_reset;
      sw_brownout_enable = s_r.sw_bor_gated;
      irq = s_r.irq;
   end
endmodule

// ===== design/rci_pkg.sv
package rci_pkg;
   // reset causes
   typedef enum logic [3:0] {
      RCI_EV_NONE = 4'h0,
      RCI_EV_POR = 4'h1,
      RCI_EV_BOR = 4'h2,
      RCI_EV_RESET_INSTR = 4'h3,
      RCI_EV_PINRST_FULL = 4'h4,
      RCI_EV_PINRST_RUN = 4'h5,
      RCI_EV_PINRST_IDLE = 4'h6,
      RCI_EV_WDT_RUN = 4'h7,
      RCI_EV_WDT_IDLE = 4'h8,
      RCI_EV_STK_FULL = 4'h9,
      RCI_EV_STK_UNF = 4'hA,
      RCI_EV_INT_WAKE = 4'hB
   } rci_event_type;

   // register categories
   typedef enum logic [1:0] {
      RCI_CAT_NONE = 2'h0,
      RCI_CAT_POWER = 2'h1,
      RCI_CAT_RESET = 2'h3,
      RCI_CAT_WAKE = 2'h2
   } rci_cat_type;

   // sequencer states, gray along idle -> decode -> apply
   typedef enum logic [1:0] {
      RCI_ST_IDLE = 2'h0,
      RCI_ST_DECODE = 2'h1,
      RCI_ST_APPLY = 2'h3
   } rci_state_type;

   localparam logic [20:0] RCI_RESET_VECTOR = 21'h000000;
   localparam logic [20:0] RCI_HIGH_VECTOR = 21'h000008;
   localparam logic [20:0] RCI_LOW_VECTOR = 21'h000018;
   localparam logic [20:0] RCI_PC_STEP = 21'h000002;
   localparam logic [1:0] RCI_BOR_SW_CONFIG = 2'h1;
   localparam logic [4:0] RCI_STACK_PTR_MAX = 5'h1F;
   localparam logic [7:0] RCI_INTCTL2_INIT = 8'hFF;
   localparam logic [7:0] RCI_INTCTL3_INIT = 8'hC0;
   localparam logic [7:0] RCI_ZERO8 = 8'h00;

   // status register bit positions, apb map
   localparam int RCI_STAT_SWBOR_BIT = 6;
   localparam int RCI_STAT_IRST_BIT = 4;
   localparam int RCI_STAT_TMO_BIT = 3;
   localparam int RCI_STAT_PDN_BIT = 2;
   localparam int RCI_STAT_POR_BIT = 1;
   localparam int RCI_STAT_BOR_BIT = 0;
   localparam logic [7:0] RCI_ADDR_STATUS = 8'h00;
   localparam logic [7:0] RCI_ADDR_STACK = 8'h04;
   localparam logic [7:0] RCI_ADDR_PC = 8'h08;
   localparam logic [7:0] RCI_ADDR_TOS = 8'h0C;
   localparam logic [7:0] RCI_ADDR_INTCTL = 8'h10;
   localparam logic [7:0] RCI_ADDR_PCLAT = 8'h14;
   localparam logic [7:0] RCI_ADDR_TBLPTR = 8'h18;
   localparam logic [7:0] RCI_ADDR_CAUSE = 8'h1C;
   localparam logic [7:0] RCI_ADDR_INT_STAT = 8'h20;
   localparam logic [7:0] RCI_ADDR_INT_MASK = 8'h24;
   localparam logic [7:0] RCI_ADDR_CTRL = 8'h28;
   localparam int RCI_NUM_EVENTS = 12;
endpackage

// ===== test/rci_monitor.sv
`timescale 1ns/10ps
module rci_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire rci_pkg::rci_event_type event_code,
   input wire logic event_valid,
   input wire logic [1:0] brownout_config_field,
   input wire logic stack_fault_reset_enable,
   input wire logic [20:0] pc_current,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [20:0] pc_out,
   input wire logic core_reset,
   input wire logic sw_brownout_enable,
   input wire logic irq
);
   import rci_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_ev(ev);
      event_valid && event_code == ev;
   endsequence
   a_ready_next: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_unmapped_err: assert property (psel && !penable && paddr > RCI_ADDR_CTRL |=> pslverr)
      else $error("unmapped access not refused");
   a_reset_single: assert property (core_reset |=> !core_reset)
      else $error("reset pulse too long");
   a_reset_pc_zero: assert property (core_reset |-> pc_out == RCI_RESET_VECTOR)
      else $error("reset without zero pc");
   a_sbor_gate: assert property (brownout_config_field != RCI_BOR_SW_CONFIG |=> !sw_brownout_enable)
      else $error("brown-out enable not gated");
   a_por_resets: assert property (s_ev(RCI_EV_POR) |-> ##[2:5] core_reset)
      else $error("power-on gave no reset");
   a_wdt_idle_step: assert property (s_ev(RCI_EV_WDT_IDLE) |-> ##[2:5] pc_out == pc_current + RCI_PC_STEP)
      else $error("idle wake pc wrong");
   a_unf_no_reset: assert property (s_ev(RCI_EV_STK_UNF) ##0 !stack_fault_reset_enable |=> !core_reset [*6])
      else $error("underflow reset while disabled");
endmodule

// ===== test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import rci_pkg::*;
   localparam logic [20:0] PC_NOW = 21'h001234;
   logic sys_clk;
   logic rst_n;
   rci_event_type event_code;
   logic event_valid;
   logic [1:0] brownout_config_field;
   logic stack_fault_reset_enable;
   logic [20:0] pc_current;
   logic [7:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [20:0] pc_out;
   logic core_reset;
   logic sw_brownout_enable;
   logic irq;
   logic [31:0] rdat;
   logic rerr;
   int n_mismatch;
   int cmp_count;

   rci_reset_init dut (.sys_clk(sys_clk), .rst_n(rst_n), .event_code(event_code), .event_valid(event_valid),
      .brownout_config_field(brownout_config_field), .stack_fault_reset_enable(stack_fault_reset_enable),
      .pc_current(pc_current), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pc_out(pc_out), .core_reset(core_reset),
      .sw_brownout_enable(sw_brownout_enable), .irq(irq));

   always #25 sys_clk = ~sys_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulse(input rci_event_type ev);
      @(posedge sys_clk);
      event_code <= ev;
      event_valid <= 1'b1;
      @(posedge sys_clk);
      event_valid <= 1'b0;
   endtask

   task automatic fire(input rci_event_type ev, input logic [7:0] rc, input logic rs, input logic [20:0] pc);
      logic seen;
      seen = 1'b0;
      pulse(ev);
      repeat (7) begin
         @(posedge sys_clk);
         seen = seen | core_reset;
      end
      check(32'(seen), 32'(rs));
      if (ev != RCI_EV_STK_UNF) begin
         check(32'(pc_out), 32'(pc));
      end
      apb(1'b0, RCI_ADDR_STATUS, 32'h0);
      check(32'(rdat[7:0]), 32'(rc));
   endtask

   task automatic t_reset_values();
      apb(1'b0, RCI_ADDR_STATUS, 32'h0);
      check(rdat, 32'h0000001C);
      apb(1'b0, RCI_ADDR_INTCTL, 32'h0);
      check(32'(rdat[23:8]), 32'h0000C0FF);
      check(32'({irq, core_reset}), 32'h0);
      $display("test reset values done");
   endtask

   task automatic t_causes();
      fire(RCI_EV_POR, 8'h5C, 1'b1, RCI_RESET_VECTOR);
      check(32'(sw_brownout_enable), 32'h1);
      brownout_config_field <= 2'b10;
      apb(1'b0, RCI_ADDR_STATUS, 32'h0);
      check(32'(rdat[6]), 32'h0);
      check(32'(sw_brownout_enable), 32'h0);
      brownout_config_field <= 2'b01;
      fire(RCI_EV_RESET_INSTR, 8'h4C, 1'b1, RCI_RESET_VECTOR);
      fire(RCI_EV_WDT_RUN, 8'h44, 1'b1, RCI_RESET_VECTOR);
      fire(RCI_EV_PINRST_RUN, 8'h4C, 1'b1, RCI_RESET_VECTOR);
      fire(RCI_EV_PINRST_IDLE, 8'h48, 1'b1, RCI_RESET_VECTOR);
      fire(RCI_EV_PINRST_FULL, 8'h48, 1'b1, RCI_RESET_VECTOR);
      apb(1'b1, RCI_ADDR_CTRL, 32'h0);
      fire(RCI_EV_BOR, 8'h1C, 1'b1, RCI_RESET_VECTOR);
      fire(RCI_EV_WDT_IDLE, 8'h10, 1'b0, PC_NOW + RCI_PC_STEP);
      fire(RCI_EV_INT_WAKE, 8'h10, 1'b0, PC_NOW + RCI_PC_STEP);
      $display("test reset causes done");
   endtask

   task automatic t_stack();
      fire(RCI_EV_STK_FULL, 8'h10, 1'b1, RCI_RESET_VECTOR);
      apb(1'b0, RCI_ADDR_STACK, 32'h0);
      check(32'(rdat[7]), 32'h1);
      stack_fault_reset_enable <= 1'b0;
      fire(RCI_EV_STK_UNF, 8'h10, 1'b0, RCI_RESET_VECTOR);
      apb(1'b0, RCI_ADDR_STACK, 32'h0);
      check(32'(rdat[6]), 32'h1);
      stack_fault_reset_enable <= 1'b1;
      fire(RCI_EV_POR, 8'h5C, 1'b1, RCI_RESET_VECTOR);
      apb(1'b0, RCI_ADDR_STACK, 32'h0);
      check(32'(rdat[7:6]), 32'h0);
      apb(1'b0, RCI_ADDR_INTCTL, 32'h0);
      check(32'(rdat[23:8]), 32'h0000C0FF);
      $display("test stack faults done");
   endtask

   task automatic t_vector();
      apb(1'b1, RCI_ADDR_INTCTL, 32'h00C0FF80);
      fire(RCI_EV_INT_WAKE, 8'h58, 1'b0, RCI_HIGH_VECTOR);
      apb(1'b0, RCI_ADDR_TOS, 32'h0);
      check(rdat, 32'(PC_NOW));
      apb(1'b0, RCI_ADDR_STACK, 32'h0);
      check(rdat, 32'h00000001);
      apb(1'b1, RCI_ADDR_INTCTL, 32'h00C0FF40);
      fire(RCI_EV_INT_WAKE, 8'h58, 1'b0, RCI_LOW_VECTOR);
      apb(1'b0, RCI_ADDR_STACK, 32'h0);
      check(rdat, 32'h00000002);
      fire(RCI_EV_PINRST_FULL, 8'h58, 1'b1, RCI_RESET_VECTOR);
      apb(1'b0, RCI_ADDR_TOS, 32'h0);
      check(rdat, 32'h00000000);
      apb(1'b0, RCI_ADDR_STACK, 32'h0);
      check(rdat, 32'h00000000);
      apb(1'b0, RCI_ADDR_INTCTL, 32'h0);
      check(rdat, 32'h00C0FF00);
      $display("test vectored wake done");
   endtask

   task automatic t_irq();
      check(32'(irq), 32'h0);
      apb(1'b0, RCI_ADDR_INT_STAT, 32'h0);
      pulse(RCI_EV_PINRST_FULL);
      repeat (7) @(posedge sys_clk);
      check(32'(irq), 32'h0);
      // bit 4 is the full-power master-clear cause
      apb(1'b1, RCI_ADDR_INT_MASK, 32'h00000010);
      repeat (2) @(posedge sys_clk);
      check(32'(irq), 32'h1);
      apb(1'b0, RCI_ADDR_INT_STAT, 32'h0);
      check(32'(rdat[4]), 32'h1);
      repeat (2) @(posedge sys_clk);
      check(32'(irq), 32'h0);
      $display("test interrupt done");
   endtask

   task automatic t_apb_err();
      apb(1'b0, 8'h30, 32'h0);
      check(32'(rerr), 32'h1);
      apb(1'b0, RCI_ADDR_CTRL, 32'h0);
      check(32'(rerr), 32'h0);
      $display("test bus error done");
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      summarize();
   end

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      event_code = RCI_EV_NONE;
      event_valid = 1'b0;
      brownout_config_field = 2'b01;
      stack_fault_reset_enable = 1'b1;
      pc_current = PC_NOW;
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset_values();
      t_causes();
      t_stack();
      t_vector();
      t_irq();
      t_apb_err();
      summarize();
   end
endmodule

bind rci_reset_init rci_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .event_code(event_code),
   .event_valid(event_valid), .brownout_config_field(brownout_config_field),
   .stack_fault_reset_enable(stack_fault_reset_enable), .pc_current(pc_current), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pc_out(pc_out), .core_reset(core_reset), .sw_brownout_enable(sw_brownout_enable), .irq(irq));
